//--- rtl/cfg_id_pkg.sv
// constants shared by the dma configuration register bank
package cfg_id_pkg;
    // register byte offsets on the axi4-lite slave
    localparam logic [11:0] event_security_off = 12'h00c;
    localparam logic [11:0] request_security_off = 12'h010;
    localparam logic [11:0] build_config_off = 12'h014;
    localparam int addr_width = 12;
    localparam int data_width = 32;
    // build config field positions (lsb)
    localparam int buf_depth_lsb = 20;
    localparam int rd_queue_lsb = 16;
    localparam int rd_cap_lsb = 12;
    localparam int wr_queue_lsb = 8;
    localparam int wr_cap_lsb = 4;
    localparam int bus_width_lsb = 0;
    // bus width codes
    localparam logic [2:0] bus_width_32 = 3'h2;
    localparam logic [2:0] bus_width_64 = 3'h3;
    localparam logic [2:0] bus_width_128 = 3'h4;
    // axi responses
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    // reset value of the captured security masks
    localparam logic [31:0] security_reset = 32'h0000_0000;
endpackage : cfg_id_pkg

//--- rtl/cfg_rom.sv
// small registered read store for the three configuration words
`timescale 1ns/1ps
`default_nettype none
module cfg_rom (
    input wire logic clk_sys_in, // system clock
    input wire logic resetn_in, // sync reset, active low
    input wire logic rd_en_in, // load read word
    input wire logic [1:0] rd_sel_in, // 0 event, 1 request, 2 build, 3 none
    input wire logic [31:0] word0_in, // event security word
    input wire logic [31:0] word1_in, // request security word
    input wire logic [31:0] word2_in, // build config word
    output logic [31:0] rd_data_out // registered read data
);
    // read data held until next read; unused select reads as zero
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            rd_data_out <= 32'h0000_0000;
        end else if (rd_en_in) begin
            case (rd_sel_in)
                2'h0: rd_data_out <= word0_in;
                2'h1: rd_data_out <= word1_in;
                2'h2: rd_data_out <= word2_in;
                default: rd_data_out <= 32'h0000_0000;
            endcase
        end
    end
endmodule : cfg_rom
`default_nettype wire

//--- rtl/dma_config_id_registers.sv
// read-only security and build configuration registers on axi4-lite
// Contract
// RL1: event bit reads 1 when non-secure
// RL2: event bits captured from ties at reset exit
// RL3: event bits above built count read zero
// RL4: request bit reads 1 when non-secure
// RL5: request bits captured from ties at reset exit
// RL6: request bits above built count read zero
// RL7: buffer depth lines minus one, bits 29:20
// RL8: read queue depth minus one, bits 19:16
// RL9: read capability minus one, bits 14:12
// RL10: write queue depth minus one, four bits
// RL11: write capability minus one, bits 6:4
// RL12: bus width code in bits 2:0
// RL13: registers read-only, writes ignored
// RL14: write queue depth in bits 11:8
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dma_config_id_registers #(
    parameter int num_events = 32, // built event/interrupt resources, 1..32
    parameter int num_requests = 32, // built request interfaces, 1..32
    parameter int buf_lines = 1024, // data buffer lines, 1..1024
    parameter int rd_queue_lines = 16, // read queue lines, 1..16
    parameter int wr_queue_lines = 16, // write queue lines, 1..16
    parameter int rd_cap = 8, // outstanding reads, 1..8
    parameter int wr_cap = 8, // outstanding writes, 1..8
    parameter int bus_bits = 64 // master data width, 32, 64 or 128
) (
    input wire logic clk_sys_in, // system clock
    input wire logic resetn_in, // sync reset, active low
    input wire logic [31:0] boot_event_security_tie_in, // per-event ns ties
    input wire logic [31:0] boot_request_security_tie_in, // per-request ns ties
    input wire logic [cfg_id_pkg::addr_width-1:0] s_axi_awaddr_in, // write address
    input wire logic s_axi_awvalid_in, // write address valid
    output logic s_axi_awready_out, // write address ready
    input wire logic [31:0] s_axi_wdata_in, // write data, ignored
    input wire logic [3:0] s_axi_wstrb_in, // write strobes, ignored
    input wire logic s_axi_wvalid_in, // write data valid
    output logic s_axi_wready_out, // write data ready
    output logic [1:0] s_axi_bresp_out, // write response
    output logic s_axi_bvalid_out, // write response valid
    input wire logic s_axi_bready_in, // write response ready
    input wire logic [cfg_id_pkg::addr_width-1:0] s_axi_araddr_in, // read address
    input wire logic s_axi_arvalid_in, // read address valid
    output logic s_axi_arready_out, // read address ready
    output logic [31:0] s_axi_rdata_out, // read data
    output logic [1:0] s_axi_rresp_out, // read response
    output logic s_axi_rvalid_out, // read data valid
    input wire logic s_axi_rready_in // read data ready
);
    import cfg_id_pkg::*;

    typedef enum logic [3:0] {
        rd_idle = 4'b0001,
        rd_fetch = 4'b0010,
        rd_load = 4'b0100,
        rd_answer = 4'b1000
    } rd_state_e;

    // field value minus one, cut to the field width
    function automatic logic [9:0] minus_one(input int value);
        minus_one = 10'(value - 1);
    endfunction : minus_one

    // mask of implemented bits for a resource count
    function automatic logic [31:0] built_mask(input int count);
        built_mask = (count >= 32) ? 32'hffff_ffff : 32'((64'h1 << count) - 64'h1);
    endfunction : built_mask

    // map the built bus width to its code; unsupported widths fall to 32-bit
    function automatic logic [2:0] width_code(input int bits);
        if (bits == 128) begin
            width_code = bus_width_128;
        end else if (bits == 64) begin
            width_code = bus_width_64;
        end else if (bits == 32) begin
            width_code = bus_width_32;
        end else begin
            width_code = bus_width_32; // reserved codes are never reported
        end
    endfunction : width_code

    // byte offset to store select; 3 marks an unmapped offset
    function automatic logic [1:0] reg_select(input logic [addr_width-1:0] addr);
        if (addr == event_security_off) begin
            reg_select = 2'h0;
        end else if (addr == request_security_off) begin
            reg_select = 2'h1;
        end else if (addr == build_config_off) begin
            reg_select = 2'h2;
        end else begin
            reg_select = 2'h3;
        end
    endfunction : reg_select

    // captured security masks and the fixed build fields
    logic [31:0] event_nonsecure_mask;
    logic [31:0] request_if_nonsecure_mask;
    logic capture_pending;
    logic [9:0] buf_depth_field;
    logic [3:0] rd_queue_field;
    logic [2:0] rd_cap_field;
    logic [3:0] wr_queue_field;
    logic [2:0] wr_cap_field;
    logic [2:0] bus_width_field;
    logic [31:0] build_word;

    // read side
    rd_state_e rd_state;
    logic [1:0] rd_sel;
    logic rd_err;
    logic rd_en;
    logic [31:0] rd_word;
    logic ar_take;
    logic r_done;

    // write side
    logic aw_held;
    logic w_held;
    logic aw_take;
    logic w_take;
    logic b_done;
    logic wr_complete;

    // read channel strobes
    assign ar_take = s_axi_arvalid_in && s_axi_arready_out;
    assign r_done = s_axi_rvalid_out && s_axi_rready_in;
    // write channel strobes
    assign aw_take = s_axi_awvalid_in && s_axi_awready_out;
    assign w_take = s_axi_wvalid_in && s_axi_wready_out;
    assign b_done = s_axi_bvalid_out && s_axi_bready_in;
    // both halves in hand and no response pending
    assign wr_complete = aw_held && w_held && !s_axi_bvalid_out;

    // ties are sampled on the first clock after reset release, never under reset
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            capture_pending <= 1'b1;
        end else begin
            capture_pending <= 1'b0;
        end
    end

    // event mask changes only at reset exit; bus writes never reach it
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            event_nonsecure_mask <= security_reset;
        end else if (capture_pending) begin
            // 1 means non-secure, 0 secure (see RL1)
            event_nonsecure_mask <= boot_event_security_tie_in
                & built_mask(num_events); // see RL2, see RL3
        end
    end

    // request mask follows the same once-only capture
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            request_if_nonsecure_mask <= security_reset;
        end else if (capture_pending) begin
            // same polarity as the event mask (see RL4)
            request_if_nonsecure_mask <= boot_request_security_tie_in
                & built_mask(num_requests); // see RL5, see RL6
        end
    end

    // field codes from fixed parameters; each cut to its field width on purpose
    assign buf_depth_field = minus_one(buf_lines); // see RL7
    assign rd_queue_field = 4'(minus_one(rd_queue_lines)); // see RL8
    assign rd_cap_field = 3'(minus_one(rd_cap)); // see RL9
    assign wr_queue_field = 4'(minus_one(wr_queue_lines)); // see RL10
    assign wr_cap_field = 3'(minus_one(wr_cap)); // see RL11
    assign bus_width_field = width_code(bus_bits); // see RL12

    // build word assembly; reserved bits 31:30, 15, 7 and 3 read zero
    always_comb begin
        build_word = 32'h0000_0000;
        build_word[buf_depth_lsb +: 10] = buf_depth_field;
        build_word[rd_queue_lsb +: 4] = rd_queue_field;
        build_word[rd_cap_lsb +: 3] = rd_cap_field;
        build_word[wr_queue_lsb +: 4] = wr_queue_field; // see RL14
        build_word[wr_cap_lsb +: 3] = wr_cap_field;
        build_word[bus_width_lsb +: 3] = bus_width_field;
    end

    // read timing: take at t, store loads at t+1, output word and rvalid at t+2
    // read sequencer: the extra load stage keeps rdata and rvalid in step
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            rd_state <= rd_idle;
        end else begin
            case (rd_state)
                rd_idle: begin
                    if (ar_take) begin
                        rd_state <= rd_fetch;
                    end
                end
                rd_fetch: begin
                    rd_state <= rd_load;
                end
                rd_load: begin
                    rd_state <= rd_answer;
                end
                rd_answer: begin
                    if (s_axi_rready_in) begin
                        rd_state <= rd_idle;
                    end
                end
                default: begin
                    rd_state <= rd_idle;
                end
            endcase
        end
    end

    // arready only in idle and dropped on the take edge: one read at a time
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            s_axi_arready_out <= 1'b0;
        end else begin
            s_axi_arready_out <= (rd_state == rd_idle) && !ar_take;
        end
    end

    // store select, latched with the address and held for the whole read
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            rd_sel <= 2'h3;
        end else if (ar_take) begin
            rd_sel <= reg_select(s_axi_araddr_in);
        end
    end

    // unmapped offsets answer slverr with zero data
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            rd_err <= 1'b0;
        end else if (ar_take) begin
            rd_err <= (reg_select(s_axi_araddr_in) == 2'h3);
        end
    end

    // rvalid rises with the output word, never ahead of it, and stands until rready
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            s_axi_rvalid_out <= 1'b0;
        end else if (rd_state == rd_load) begin
            s_axi_rvalid_out <= 1'b1;
        end else if (r_done) begin
            s_axi_rvalid_out <= 1'b0;
        end
    end

    // response code set with rvalid and held with it
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            s_axi_rresp_out <= resp_okay;
        end else if (rd_state == rd_load) begin
            s_axi_rresp_out <= rd_err ? resp_slverr : resp_okay;
        end
    end

    // the store loads in fetch; its word reaches the output one edge later
    assign rd_en = (rd_state == rd_fetch);

    // registered read store keeps rdata stable while rvalid waits
    cfg_rom u_cfg_rom (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .rd_en_in(rd_en),
        .rd_sel_in(rd_sel),
        .word0_in(event_nonsecure_mask),
        .word1_in(request_if_nonsecure_mask),
        .word2_in(build_word),
        .rd_data_out(rd_word)
    );

    // output word loads in the load state, so it is settled when rvalid rises
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            s_axi_rdata_out <= 32'h0000_0000;
        end else if (rd_state == rd_load) begin
            s_axi_rdata_out <= rd_word;
        end
    end

    // write timing: halves taken in either order, response one edge after the later
    // address half of a write, kept until the response goes out
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            aw_held <= 1'b0;
        end else if (wr_complete) begin
            aw_held <= 1'b0;
        end else if (aw_take) begin
            aw_held <= 1'b1;
        end
    end

    // data half of a write; its content is dropped, nothing stores it
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            w_held <= 1'b0;
        end else if (wr_complete) begin
            w_held <= 1'b0;
        end else if (w_take) begin
            w_held <= 1'b1;
        end
    end

    // awready falls once the address is taken and returns after the response
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            s_axi_awready_out <= 1'b0;
        end else begin
            s_axi_awready_out <= !s_axi_bvalid_out && !aw_held && !aw_take;
        end
    end

    // wready mirrors awready for the data half
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            s_axi_wready_out <= 1'b0;
        end else begin
            s_axi_wready_out <= !s_axi_bvalid_out && !w_held && !w_take;
        end
    end

    // one response per write, standing until bready
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            s_axi_bvalid_out <= 1'b0;
        end else if (wr_complete) begin
            s_axi_bvalid_out <= 1'b1;
        end else if (b_done) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    // registers are read-only: every write answers slverr and stores nothing
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            s_axi_bresp_out <= resp_okay;
        end else if (wr_complete) begin
            s_axi_bresp_out <= resp_slverr; // see RL13
        end
    end
endmodule : dma_config_id_registers
`default_nettype wire

//--- tb/dma_config_id_registers_props.sv
// checker for the axi4-lite side of the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module cfg_id_props import cfg_id_pkg::*; (
    input wire logic clk_sys_in, // system clock
    input wire logic resetn_in, // sync reset, active low
    input wire logic [11:0] s_axi_araddr_in, // read address
    input wire logic s_axi_arvalid_in, // read address valid
    input wire logic s_axi_arready_out, // read address ready
    input wire logic [31:0] s_axi_rdata_out, // read data
    input wire logic [1:0] s_axi_rresp_out, // read response
    input wire logic s_axi_rvalid_out, // read valid
    input wire logic s_axi_rready_in, // read ready
    input wire logic s_axi_awready_out, // write address ready
    input wire logic s_axi_wready_out, // write data ready
    input wire logic [1:0] s_axi_bresp_out, // write response
    input wire logic s_axi_bvalid_out, // write response valid
    input wire logic s_axi_bready_in // write response ready
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    logic [11:0] rd_addr;
    // remember the taken read address so the answer can be judged by register
    always_ff @(posedge clk_sys_in) begin
        if (s_axi_arvalid_in && s_axi_arready_out) rd_addr <= s_axi_araddr_in;
    end
    property p_rd_answer;
        s_axi_arvalid_in && s_axi_arready_out |=> !s_axi_arready_out ##[1:2] s_axi_rvalid_out;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    property p_rd_hold;
        s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
    property p_wr_hold;
        s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out;
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");
    property p_wr_refused;
        s_axi_bvalid_out |-> s_axi_bresp_out == resp_slverr;
    endproperty
    a_wr_refused: assert property (p_wr_refused) else $error("write not refused");
    property p_unmapped_zero;
        s_axi_rvalid_out && s_axi_rresp_out == resp_slverr |-> s_axi_rdata_out == 32'h0;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("error read not zero");
    property p_one_read;
        s_axi_rvalid_out |-> !s_axi_arready_out;
    endproperty
    a_one_read: assert property (p_one_read) else $error("second read accepted");
    property p_build_reserved;
        s_axi_rvalid_out && rd_addr == build_config_off |-> s_axi_rresp_out == resp_okay
            && s_axi_rdata_out[31:30] == 2'h0 && !s_axi_rdata_out[15] && !s_axi_rdata_out[7];
    endproperty
    a_build_reserved: assert property (p_build_reserved) else $error("build word bad");
    property p_release;
        $rose(resetn_in) |-> !s_axi_arready_out && !s_axi_awready_out && !s_axi_wready_out;
    endproperty
    a_release: assert property (p_release) else $error("ready before capture");
    c_read: cover property (s_axi_rvalid_out && s_axi_rready_in);
    c_write: cover property (s_axi_bvalid_out && s_axi_bready_in);
    c_err: cover property (s_axi_rvalid_out && s_axi_rresp_out == resp_slverr);
endmodule : cfg_id_props
bind dma_config_id_registers cfg_id_props i_props (.clk_sys_in, .resetn_in, .s_axi_araddr_in,
    .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
    .s_axi_rready_in, .s_axi_awready_out, .s_axi_wready_out, .s_axi_bresp_out,
    .s_axi_bvalid_out, .s_axi_bready_in);
`default_nettype wire

//--- tb/dma_config_id_registers_tb_top.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module dma_config_id_registers_tb_top;
    import cfg_id_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [31:0] ev_tie = 32'h0, rq_tie = 32'h0;
    logic [11:0] awa = 12'h0, ara = 12'h0;
    logic [31:0] wd = 32'h0;
    logic [3:0] ws = 4'h0;
    logic awr, wr_r, bv, arr, rv;
    logic [1:0] br, rr;
    logic [31:0] rd;
    int errors = 0, comparisons = 0;
    // read and write queue and capability fields differ, so a swap shows
    localparam logic [31:0] build_exp = {2'h0, 10'h3ff, 4'h4, 1'h0, 3'h2, 4'hf, 1'h0, 3'h7, 1'h0,
        bus_width_128};
    dma_config_id_registers #(.num_events(20), .num_requests(12), .rd_queue_lines(5), .rd_cap(3),
        .bus_bits(128)) i_dut (
        .clk_sys_in(clk), .resetn_in(rst_n), .boot_event_security_tie_in(ev_tie),
        .boot_request_security_tie_in(rq_tie), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws),
        .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_r), .s_axi_bresp_out(br),
        .s_axi_bvalid_out(bv), .s_axi_bready_in(bry), .s_axi_araddr_in(ara),
        .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rd),
        .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rry));
    // 20 mhz clock
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask : check
    // ties are only looked at on the first edge after release
    task automatic boot(input logic [31:0] ev, input logic [31:0] rq);
        @(posedge clk) rst_n <= 1'b0;
        ev_tie <= ev;
        rq_tie <= rq;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask : boot
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk) arv <= 1'b1;
        ara <= a;
        rry <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arv && arr) arv <= 1'b0;
        end while (rv !== 1'b1 && n < 50);
        rry <= 1'b0;
        if (rv !== 1'b1) begin
            errors++;
            report_and_stop();
        end
        check("rdata", rd, e);
        check("rresp", {30'h0, rr}, {30'h0, er});
    endtask : rd_chk
    // address and data go out together; the answer is always an error
    task automatic wr_chk(input logic [11:0] a);
        int n;
        n = 0;
        @(posedge clk) awv <= 1'b1;
        wv <= 1'b1;
        awa <= a;
        wd <= 32'hffff_ffff;
        ws <= 4'hf;
        bry <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_r) wv <= 1'b0;
        end while (bv !== 1'b1 && n < 50);
        bry <= 1'b0;
        if (bv !== 1'b1) begin
            errors++;
            report_and_stop();
        end
        check("bresp", {30'h0, br}, {30'h0, resp_slverr});
    endtask : wr_chk
    initial begin
        boot(32'hffff_ffff, 32'hffff_ffff);
        rd_chk(event_security_off, 32'h000f_ffff, resp_okay);
        rd_chk(request_security_off, 32'h0000_0fff, resp_okay);
        rd_chk(build_config_off, build_exp, resp_okay);
        $display("test reset values done");
        @(posedge clk) ev_tie <= 32'h0;
        rq_tie <= 32'h0;
        wr_chk(event_security_off);
        wr_chk(request_security_off);
        wr_chk(build_config_off);
        rd_chk(event_security_off, 32'h000f_ffff, resp_okay);
        rd_chk(request_security_off, 32'h0000_0fff, resp_okay);
        rd_chk(build_config_off, build_exp, resp_okay);
        rd_chk(12'h018, 32'h0, resp_slverr);
        $display("test writes ignored done");
        boot(32'ha5a5_a5a5, 32'h5a5a_5a5a);
        rd_chk(event_security_off, 32'h0005_a5a5, resp_okay);
        rd_chk(request_security_off, 32'h0000_0a5a, resp_okay);
        $display("test second capture done");
        report_and_stop();
    end
endmodule : dma_config_id_registers_tb_top
`default_nettype wire
